// ---- verilog/scd_datapath.sv ----
// Subtract-with-carry datapath: operand selection, flags and write-back registers
//
// Summary of operation
// - Carrying subtract writes not(a) + b + 1 to the target register.
// - After a carrying subtract, carry is one exactly when the unsigned sum passes 32 bits.
// - The alias carrying subtract swaps both sources and writes its carry-out to carry.
// - Extended subtract writes not(a) + b + carry and takes carry from its overflow.
// - Record bit set makes register forms update all four bits of condition field zero.
// - Overflow-enable set makes register forms update both wrap flags; clear leaves both unchanged.
// - Immediate form writes not(a) + sext(constant) + 1 and changes only target and carry.
// - Minus-one form writes not(a) + all-ones + carry and sets carry on 32-bit overflow.
// - Zero extended subtract writes not(a) + carry and sets carry on overflow.
`default_nettype none
module scd_datapath #(
	parameter int unsigned DW = scd_pkg::DATA_W
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire scd_pkg::scd_req_t req,
	output logic                   wb_valid,
	output logic [4:0]             wb_target_reg,
	output logic [DW-1:0]          wb_result,
	output logic                   carry_bit,
	output logic                   sticky_wrap,
	output logic                   arith_wrap_flag,
	output logic [3:0]             cond_field_zero,
	output logic                   cond_field_zero_upd
);
	logic [DW-1:0] op_x;
	logic [DW-1:0] op_y;
	logic          cin;
	logic [DW-1:0] sum;
	logic          cout;
	logic          ovf;
	logic          is_imm;

	scd_pkg::scd_wb_t  wb_ff;
	scd_pkg::scd_wb_t  nxt_wb;
	scd_pkg::scd_fxr_t fxr_ff;
	scd_pkg::scd_fxr_t nxt_fxr;
	logic [3:0]        cfz_ff;
	logic [3:0]        nxt_cfz;
	logic              cfz_upd_ff;
	logic              nxt_cfz_upd;

	// Operand select; every form reduces to not(x) + y + cin
	always_comb begin
		op_x   = ~req.src_a;
		op_y   = req.src_b;
		cin    = 1'b1;
		is_imm = 1'b0;
		unique case (req.op)
			scd_pkg::SCD_OP_SUBF_C: begin
				cin = 1'b1;
			end
			scd_pkg::SCD_OP_SUB_C: begin
				op_x = ~req.src_b;
				op_y = req.src_a;
			end
			scd_pkg::SCD_OP_SUBF_E: begin
				cin = fxr_ff.carry_bit;
			end
			scd_pkg::SCD_OP_SUBF_IC: begin
				op_y   = {{(DW-scd_pkg::IMM_W){req.sign_ext_const[scd_pkg::IMM_W-1]}},
					req.sign_ext_const};
				is_imm = 1'b1;
			end
			scd_pkg::SCD_OP_SUBF_ME: begin
				op_y = {DW{1'b1}};
				cin  = fxr_ff.carry_bit;
			end
			scd_pkg::SCD_OP_SUBF_ZE: begin
				op_y = '0;
				cin  = fxr_ff.carry_bit;
			end
			default: begin
				op_y = req.src_b;
			end
		endcase
	end

	scd_adder #(
		.W (DW)
	) u_adder (
		.op_x (op_x),
		.op_y (op_y),
		.cin  (cin),
		.sum  (sum),
		.cout (cout),
		.ovf  (ovf)
	);

	// Flag and write-back next state
	always_comb begin
		nxt_wb       = wb_ff;
		nxt_fxr      = fxr_ff;
		nxt_cfz      = cfz_ff;
		nxt_cfz_upd  = 1'b0;
		nxt_wb.valid = req.valid;
		if (req.valid) begin
			nxt_wb.target_reg = req.target_reg;
			nxt_wb.result     = sum;
			nxt_fxr.carry_bit = cout;
			// Immediate form ignores both enable bits
			if (req.ovf_en && !is_imm) begin
				nxt_fxr.arith_wrap_flag = ovf;
				nxt_fxr.sticky_wrap     = fxr_ff.sticky_wrap | ovf;
			end
			if (req.record_bit && !is_imm) begin
				nxt_cfz_upd                 = 1'b1;
				nxt_cfz[scd_pkg::CR_LT]     = sum[DW-1];
				nxt_cfz[scd_pkg::CR_GT]     = !sum[DW-1] && (sum != '0);
				nxt_cfz[scd_pkg::CR_EQ]     = (sum == '0);
				// Sticky copy sees this instruction's own wrap
				nxt_cfz[scd_pkg::CR_SO]     = nxt_fxr.sticky_wrap;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wb_ff                  <= '0;
			fxr_ff.carry_bit       <= scd_pkg::CARRY_RST;
			fxr_ff.sticky_wrap     <= scd_pkg::STICKY_RST;
			fxr_ff.arith_wrap_flag <= scd_pkg::WRAP_RST;
			cfz_ff                 <= scd_pkg::CFZ_RST;
			cfz_upd_ff             <= 1'b0;
		end else begin
			wb_ff      <= nxt_wb;
			fxr_ff     <= nxt_fxr;
			cfz_ff     <= nxt_cfz;
			cfz_upd_ff <= nxt_cfz_upd;
		end
	end

	assign wb_valid            = wb_ff.valid;
	assign wb_target_reg       = wb_ff.target_reg;
	assign wb_result           = wb_ff.result;
	assign carry_bit           = fxr_ff.carry_bit;
	assign sticky_wrap         = fxr_ff.sticky_wrap;
	assign arith_wrap_flag     = fxr_ff.arith_wrap_flag;
	assign cond_field_zero     = cfz_ff;
	assign cond_field_zero_upd = cfz_upd_ff;

	// Checks restate the arithmetic directly, not through the adder
	a_carry_sub_res: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_C |=>
		wb_result == $past(req.src_b) - $past(req.src_a))
		else $error("carrying subtract result wrong");
	a_wb_follow: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid |=> wb_valid && wb_target_reg == $past(req.target_reg))
		else $error("write-back valid or target wrong");
	a_carry_sub_ca: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_C |=>
		carry_bit == ($past(req.src_b) >= $past(req.src_a)))
		else $error("carrying subtract carry wrong");
	a_alias_sub_res: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUB_C |=>
		wb_result == $past(req.src_a) - $past(req.src_b) &&
		carry_bit == ($past(req.src_a) >= $past(req.src_b)))
		else $error("alias subtract wrong");
	a_ext_sub_res: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_E |=>
		wb_result == ~$past(req.src_a) + $past(req.src_b) + {31'h0, $past(carry_bit)})
		else $error("extended subtract result wrong");
	a_ext_sub_ca: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_E |=>
		carry_bit == ($past(req.src_b) > $past(req.src_a) ||
		($past(req.src_b) == $past(req.src_a) && $past(carry_bit))))
		else $error("extended subtract carry wrong");
	a_cfz_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(req.valid && req.record_bit) |=> $stable(cond_field_zero))
		else $error("condition field changed without record bit");
	a_cfz_update: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.record_bit && req.op != scd_pkg::SCD_OP_SUBF_IC |=> cond_field_zero_upd)
		else $error("condition field not updated");
	a_wrap_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(req.valid && req.ovf_en) |=> $stable(arith_wrap_flag) && $stable(sticky_wrap))
		else $error("wrap flags changed without enable");
	a_imm_only_ca: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_IC |=>
		$stable(cond_field_zero) && $stable(sticky_wrap) && $stable(arith_wrap_flag))
		else $error("immediate subtract touched other flags");
	a_imm_sub_res: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_IC |=>
		wb_result == {{(DW-scd_pkg::IMM_W){$past(req.sign_ext_const[scd_pkg::IMM_W-1])}},
		$past(req.sign_ext_const)} - $past(req.src_a))
		else $error("immediate subtract result wrong");
	a_me_sub_res: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_ME |=>
		wb_result == ~$past(req.src_a) - 32'h0000_0001 + {31'h0, $past(carry_bit)})
		else $error("minus-one subtract wrong");
	a_me_sub_ca: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_ME |=>
		carry_bit == ($past(req.src_a) != '1 || $past(carry_bit)))
		else $error("minus-one subtract carry wrong");
	a_ze_sub_res: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_ZE |=>
		wb_result == ~$past(req.src_a) + {31'h0, $past(carry_bit)})
		else $error("zero subtract wrong");
	a_ze_sub_ca: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.op == scd_pkg::SCD_OP_SUBF_ZE |=>
		carry_bit == ($past(req.src_a) == '0 && $past(carry_bit)))
		else $error("zero subtract carry wrong");
	a_cfz_compare: assert property (@(posedge mclk) disable iff (sys_rst)
		cond_field_zero_upd |-> cond_field_zero[3:1] ==
		(wb_result == '0 ? 3'b001 : (wb_result[DW-1] ? 3'b100 : 3'b010)) &&
		cond_field_zero[0] == sticky_wrap)
		else $error("condition field compare wrong");
	a_wrap_compute: assert property (@(posedge mclk) disable iff (sys_rst)
		req.valid && req.ovf_en && req.op == scd_pkg::SCD_OP_SUBF_C |=>
		arith_wrap_flag == ($past(req.src_a[DW-1]) != $past(req.src_b[DW-1]) &&
		wb_result[DW-1] != $past(req.src_b[DW-1])))
		else $error("arithmetic wrap flag wrong");
	a_sticky_follow: assert property (@(posedge mclk) disable iff (sys_rst)
		arith_wrap_flag && $changed(arith_wrap_flag) |-> sticky_wrap)
		else $error("sticky wrap not set");
	a_sticky_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		sticky_wrap |=> sticky_wrap)
		else $error("sticky wrap cleared outside reset");
endmodule
`default_nettype wire

// ---- verilog/scd_pkg.sv ----
// Package for the subtract-with-carry datapath: operations, carriers, constants
`default_nettype none
package scd_pkg;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned IMM_W      = 16;
	localparam int unsigned LATENCY    = 1;
	localparam logic        CARRY_RST  = 1'b0;
	localparam logic        STICKY_RST = 1'b0;
	localparam logic        WRAP_RST   = 1'b0;
	localparam logic [3:0]  CFZ_RST    = 4'h0;
	// Condition field bit positions
	localparam int unsigned CR_LT      = 3;
	localparam int unsigned CR_GT      = 2;
	localparam int unsigned CR_EQ      = 1;
	localparam int unsigned CR_SO      = 0;

	typedef enum logic [2:0] {
		SCD_OP_SUBF_C,
		SCD_OP_SUB_C,
		SCD_OP_SUBF_E,
		SCD_OP_SUBF_IC,
		SCD_OP_SUBF_ME,
		SCD_OP_SUBF_ZE
	} scd_op_t;

	typedef struct packed {
		logic                valid;
		scd_op_t             op;
		logic                ovf_en;
		logic                record_bit;
		logic [4:0]          target_reg;
		logic [DATA_W-1:0]   src_a;
		logic [DATA_W-1:0]   src_b;
		logic [IMM_W-1:0]    sign_ext_const;
	} scd_req_t;

	typedef struct packed {
		logic                valid;
		logic [4:0]          target_reg;
		logic [DATA_W-1:0]   result;
	} scd_wb_t;

	typedef struct packed {
		logic                carry_bit;
		logic                sticky_wrap;
		logic                arith_wrap_flag;
	} scd_fxr_t;
endpackage
`default_nettype wire

// ---- verilog/scd_adder.sv ----
// Combinational three-input adder with carry-out and signed overflow
`default_nettype none
module scd_adder #(
	parameter int unsigned W = 32
) (
	input  wire logic [W-1:0] op_x,
	input  wire logic [W-1:0] op_y,
	input  wire logic         cin,
	output logic      [W-1:0] sum,
	output logic              cout,
	output logic              ovf
);
	logic [W:0] wide;

	always_comb begin
		wide = {1'b0, op_x} + {1'b0, op_y} + {{W{1'b0}}, cin};
		sum  = wide[W-1:0];
		cout = wide[W];
		// Signed wrap: like-signed inputs with a differently signed sum
		ovf  = (op_x[W-1] == op_y[W-1]) && (wide[W-1] != op_x[W-1]);
	end
endmodule
`default_nettype wire

// ---- verif/scd_rf_model.sv ----
// Register file model on the far side of the write-back port
`default_nettype none
module scd_rf_model (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        wb_valid,
	input  wire logic [4:0]  wb_target_reg,
	input  wire logic [31:0] wb_result,
	input  wire logic [4:0]  rd_idx,
	output logic      [31:0] rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] regs_ff [32];
	// Cleared on reset so read-back after a reset is defined
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < 32; i++) regs_ff[i] <= '0;
		end else if (wb_valid) begin
			regs_ff[wb_target_reg] <= wb_result;
		end
	end
	assign rd_data = regs_ff[rd_idx];
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the subtract-with-carry datapath
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic              mclk = 1'b0;
	logic              sys_rst = 1'b1;
	scd_pkg::scd_req_t req = '0;
	logic              wb_valid, carry_bit, sticky_wrap, arith_wrap_flag, cond_field_zero_upd;
	logic [4:0]        wb_target_reg;
	logic [31:0]       wb_result, rf_data;
	logic [3:0]        cond_field_zero;
	int                error_cnt = 0;
	int                comparisons = 0;
	logic [31:0]       e_res = '0;
	logic [4:0]        e_tgt = '0;
	logic              e_vld = 1'b0, e_upd = 1'b0, e_ca = 1'b0, e_so = 1'b0, e_aw = 1'b0;
	logic [3:0]        e_cr = '0;
	logic [31:0]       e_rf [32] = '{default: '0};
	always #12.5 mclk = ~mclk;
	scd_datapath i_scd_datapath (.mclk(mclk), .sys_rst(sys_rst), .req(req),
		.wb_valid(wb_valid), .wb_target_reg(wb_target_reg), .wb_result(wb_result),
		.carry_bit(carry_bit), .sticky_wrap(sticky_wrap), .arith_wrap_flag(arith_wrap_flag),
		.cond_field_zero(cond_field_zero), .cond_field_zero_upd(cond_field_zero_upd));
	scd_rf_model i_scd_rf_model (.mclk(mclk), .sys_rst(sys_rst), .wb_valid(wb_valid),
		.wb_target_reg(wb_target_reg), .wb_result(wb_result), .rd_idx(e_tgt), .rd_data(rf_data));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Edge values make carry, wrap and zero results likely
	function automatic logic [31:0] pick();
		case ($urandom_range(0, 4))
			0: return 32'h0000_0000;
			1: return 32'hFFFF_FFFF;
			2: return 32'h8000_0000;
			3: return 32'h7FFF_FFFF;
			default: return $urandom();
		endcase
	endfunction
	task automatic check_all();
		chk(wb_valid, e_vld);
		chk(wb_target_reg, e_tgt);
		chk(wb_result, e_res);
		chk(carry_bit, e_ca);
		chk({sticky_wrap, arith_wrap_flag}, {e_so, e_aw});
		chk({cond_field_zero_upd, cond_field_zero}, {e_upd, e_cr});
		// Register file takes the write-back one edge later
		chk(rf_data, e_rf[e_tgt]);
		if (e_vld) e_rf[e_tgt] = e_res;
	endtask
	task automatic step(input int i);
		logic [31:0] x, y;
		logic        cin;
		longint      s, ss;
		req.valid = ($urandom_range(0, 7) != 0);
		req.op = scd_pkg::scd_op_t'($urandom_range(0, 5));
		req.ovf_en = 1'($urandom_range(0, 1));
		req.record_bit = 1'($urandom_range(0, 1));
		req.target_reg = 5'($urandom_range(0, 31));
		req.src_a = pick();
		req.src_b = pick();
		req.sign_ext_const = 16'($urandom());
		// Mid-run reset clears every flag
		sys_rst = (i % 200 == 199);
		e_upd = 1'b0;
		e_vld = req.valid && !sys_rst;
		if (sys_rst) begin
			{e_res, e_tgt, e_ca, e_so, e_aw, e_cr} = '0;
			e_rf = '{default: '0};
			return;
		end
		if (!req.valid) return;
		x = ~req.src_a;
		y = req.src_b;
		cin = 1'b1;
		case (req.op)
			scd_pkg::SCD_OP_SUB_C: begin
				x = ~req.src_b;
				y = req.src_a;
			end
			scd_pkg::SCD_OP_SUBF_E: cin = e_ca;
			scd_pkg::SCD_OP_SUBF_IC: y = {{16{req.sign_ext_const[15]}}, req.sign_ext_const};
			scd_pkg::SCD_OP_SUBF_ME: {y, cin} = {32'hFFFF_FFFF, e_ca};
			scd_pkg::SCD_OP_SUBF_ZE: {y, cin} = {32'h0000_0000, e_ca};
			default: ;
		endcase
		s = longint'(x) + longint'(y) + longint'(cin);
		e_res = s[31:0];
		e_ca = s[32];
		e_tgt = req.target_reg;
		// Immediate form leaves wrap flags and the condition field alone
		if (req.op == scd_pkg::SCD_OP_SUBF_IC) return;
		if (req.ovf_en) begin
			// Signed range test on a wide sum, not a sign-bit pattern
			ss = longint'($signed(x)) + longint'($signed(y)) + longint'(cin);
			e_aw = (ss > 64'sh0000_0000_7FFF_FFFF) || (ss < -64'sh0000_0000_8000_0000);
			e_so = e_so | e_aw;
		end
		if (req.record_bit) begin
			e_upd = 1'b1;
			e_cr = {$signed(e_res) < 32'sh0000_0000, $signed(e_res) > 32'sh0000_0000,
				e_res == 32'h0000_0000, e_so};
		end
	endtask
	initial begin
		#(25 * 2000);
		error_cnt++;
		print_verdict();
	end
	initial begin
		void'($urandom(20));
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		for (int i = 0; i < 600; i++) begin
			check_all();
			step(i);
			@(negedge mclk);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
